// >>> rtl/ptc_clock_config.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
// ****************************************************************
// PWM timer clock configuration
// ****************************************************************
// Overview of operation
// - Reset clears configuration register to zero
// - Timer source frozen during run mode
// - PLL enable writes ignored in run
// - Divider field selects 8/4/2/1 division
// - Divider change waits for counter overflow in run mode
// - Reads return last written divider and prescaler values
// - Source bit picks instruction clock or PLL
// - Source set needs PLL, frozen in run
// - Core select picks osc/2 or PLL/8
// - Core select forced zero without PLL
// - Core select changes anytime with PLL
// - Prescaler divides timer clock by sel+1
// - Prescaler change waits for counter overflow in run mode
// - Run mode: PWM started or capture mode
module ptc_clock_config (
    input  wire logic       ref_clk,            // 10 MHz system clock
    input  wire logic       rst_n,              // Asynchronous reset
    input  wire logic [7:0] addr,               // Register address
    input  wire logic [7:0] wdata,              // Write data
    input  wire logic       wr_en,              // Write strobe
    input  wire logic       rd_en,              // Read strobe
    output logic      [7:0] rdata,              // Read data, next cycle
    input  wire logic       capture_mode,       // Timer in capture mode
    input  wire logic       pwm_counter_run,    // PWM counter started
    input  wire logic       pwm_counter_ovf,    // Counter overflow pulse
    input  wire logic       pll_out_tick,       // PLL base clock pulse
    input  wire logic       osc_tick,           // Oscillator clock pulse
    output logic            pll_on,             // PLL enable
    output logic      [1:0] pll_divide_sel,     // Active PLL divider
    output logic            timer_src_sel,      // Timer source select
    output logic            fast_core_clk_sel,  // Core clock select
    output logic      [2:0] timer_prescale_sel, // Active prescaler
    output logic            timer_clk,          // Timer clock pulse
    output logic            core_instr_clk,     // Core clock pulse
    output logic            pwm_counter_tick    // Counter step pulse
);

    // ************************************************************
    // Declarations
    // ************************************************************
    ptc_pkg::ptc_config_type cfg;          // Software-visible register
    ptc_pkg::ptc_active_type active;       // Settings in the clock path
    ptc_pkg::ptc_config_type next_cfg;     // Register after a write
    logic                    run_mode;     // Timer considered running
    logic                    run_mode_q;   // Run mode one cycle ago
    logic                    cfg_hit;      // Address decode
    logic [3:0]              pll_cnt;      // PLL divide counter
    logic                    pll_div_tick; // Divided PLL pulse
    logic [2:0]              pll8_cnt;     // Fixed divide-by-8 counter
    logic                    pll8_tick;    // PLL divide-by-8 pulse
    logic                    osc_half;     // Oscillator divide-by-2
    logic                    osc2_tick;    // Oscillator/2 pulse
    logic [7:0]              cfg_bits;     // Register as raw bits

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Division ratio minus one for a divider code
    function automatic logic [3:0] pll_div_limit(input ptc_pkg::ptc_pll_div_type sel);
        case (sel)
            ptc_pkg::PTC_DIV8: pll_div_limit = 4'h7;
            ptc_pkg::PTC_DIV4: pll_div_limit = 4'h3;
            ptc_pkg::PTC_DIV2: pll_div_limit = 4'h1;
            default:           pll_div_limit = 4'h0;
        endcase
    endfunction : pll_div_limit

    // ************************************************************
    // Run mode and decode
    // ************************************************************
    assign run_mode = capture_mode || pwm_counter_run;
    assign cfg_hit  = (addr == ptc_pkg::CLOCK_PRESCALE_CONFIG_OFFSET);
    assign cfg_bits = cfg;

    // ************************************************************
    // Write filtering
    // ************************************************************
    always_comb begin
        next_cfg = cfg;
        // Divider and prescaler always stored as written
        next_cfg.pll_divide_sel     =
            ptc_pkg::ptc_pll_div_type'(wdata[ptc_pkg::PLL_DIVIDE_SEL_LSB +: 2]);
        next_cfg.timer_prescale_sel = wdata[ptc_pkg::TIMER_PRESCALE_SEL_LSB +: 3];
        // PLL enable only outside run mode
        if (!run_mode) begin
            next_cfg.pll_on = wdata[ptc_pkg::PLL_ON_POS];
        end
        // Timer source: not in run, set needs PLL on
        if (!run_mode) begin
            if (!wdata[ptc_pkg::TIMER_SRC_SEL_POS] || next_cfg.pll_on) begin
                next_cfg.timer_src_sel = wdata[ptc_pkg::TIMER_SRC_SEL_POS];
            end
        end
        // Core select free while PLL on, else forced low
        if (next_cfg.pll_on) begin
            next_cfg.fast_core_clk_sel = wdata[ptc_pkg::FAST_CORE_CLK_SEL_POS];
        end else begin
            next_cfg.fast_core_clk_sel = 1'b0;
        end
    end

    // ************************************************************
    // Configuration register
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= ptc_pkg::ptc_config_type'(ptc_pkg::CLOCK_PRESCALE_CONFIG_RESET);
        end else if (wr_en && cfg_hit) begin
            cfg <= next_cfg;
        end
    end

    // ************************************************************
    // Run-mode tracking for prescaler restart
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_mode_q <= 1'b0;
        end else begin
            run_mode_q <= run_mode;
        end
    end

    // ************************************************************
    // Active divider and prescaler (shadow load)
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= ptc_pkg::ptc_active_type'(5'h0_0);
        end else if (!run_mode || pwm_counter_ovf) begin
            // Outside run follow the register; in run load at overflow
            active.pll_divide_sel     <= cfg.pll_divide_sel;
            active.timer_prescale_sel <= cfg.timer_prescale_sel;
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00_00;
        end else if (rd_en && cfg_hit) begin
            rdata <= cfg_bits;
        end else begin
            rdata <= ptc_pkg::UNMAPPED_READ_VALUE;
        end
    end

    // ************************************************************
    // PLL output divider
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_cnt <= 4'h0;
        end else if (!cfg.pll_on) begin
            pll_cnt <= 4'h0;
        end else if (pll_out_tick) begin
            if (pll_cnt >= pll_div_limit(active.pll_divide_sel)) begin
                pll_cnt <= 4'h0;
            end else begin
                pll_cnt <= pll_cnt + 4'h1;
            end
        end
    end
    // Divided PLL pulse
    assign pll_div_tick = cfg.pll_on && pll_out_tick
                          && (pll_cnt >= pll_div_limit(active.pll_divide_sel));

    // ************************************************************
    // Fixed PLL divide-by-8 for the core clock
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pll8_cnt <= 3'h0;
        end else if (!cfg.pll_on) begin
            pll8_cnt <= 3'h0;
        end else if (pll_out_tick) begin
            pll8_cnt <= pll8_cnt + 3'h1;
        end
    end
    assign pll8_tick = cfg.pll_on && pll_out_tick && (pll8_cnt == 3'h7);

    // ************************************************************
    // Oscillator divide-by-2
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_half <= 1'b0;
        end else if (osc_tick) begin
            osc_half <= !osc_half;
        end
    end
    assign osc2_tick = osc_tick && osc_half;

    // ************************************************************
    // Clock source selection
    // ************************************************************
    // Core clock: osc/2 or PLL/8
    assign core_instr_clk = cfg.fast_core_clk_sel ? pll8_tick : osc2_tick;
    // Timer clock: instruction clock or divided PLL
    assign timer_clk      = cfg.timer_src_sel ? pll_div_tick : core_instr_clk;

    // ************************************************************
    // Prescaler
    // ************************************************************
    ptc_prescaler u_prescaler (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .src_tick   (timer_clk),
        .restart    (run_mode && !run_mode_q),
        .div_sel    (active.timer_prescale_sel),
        .count_tick (pwm_counter_tick)
    );

    // ************************************************************
    // Status outputs
    // ************************************************************
    assign pll_on             = cfg.pll_on;
    assign pll_divide_sel     = active.pll_divide_sel;
    assign timer_src_sel      = cfg.timer_src_sel;
    assign fast_core_clk_sel  = cfg.fast_core_clk_sel;
    assign timer_prescale_sel = active.timer_prescale_sel;

endmodule : ptc_clock_config

// >>> rtl/ptc_pkg.sv
// ****************************************************************
// Clock configuration constants and types
// ****************************************************************
package ptc_pkg;

    // Register offset and reset value
    localparam logic [7:0] CLOCK_PRESCALE_CONFIG_OFFSET = 8'h00_A4;
    localparam logic [7:0] CLOCK_PRESCALE_CONFIG_RESET  = 8'h00_00;

    // Field positions
    localparam int PLL_ON_POS             = 7;
    localparam int PLL_DIVIDE_SEL_LSB     = 5;
    localparam int TIMER_SRC_SEL_POS      = 4;
    localparam int FAST_CORE_CLK_SEL_POS  = 3;
    localparam int TIMER_PRESCALE_SEL_LSB = 0;

    // Unmapped read answer
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00_00;

    // PLL divider encodings
    typedef enum logic [1:0] {
        PTC_DIV8 = 2'h0,
        PTC_DIV4 = 2'h1,
        PTC_DIV2 = 2'h2,
        PTC_DIV1 = 2'h3
    } ptc_pll_div_type;

    // Register fields
    typedef struct packed {
        logic            pll_on;
        ptc_pll_div_type pll_divide_sel;
        logic            timer_src_sel;
        logic            fast_core_clk_sel;
        logic [2:0]      timer_prescale_sel;
    } ptc_config_type;

    // Settings applied to the active clock path
    typedef struct packed {
        ptc_pll_div_type pll_divide_sel;
        logic [2:0]      timer_prescale_sel;
    } ptc_active_type;

endpackage : ptc_pkg

// >>> rtl/ptc_prescaler.sv
`timescale 1ns/1ns
// ****************************************************************
// Timer clock prescaler: one tick every (sel + 1) source pulses
// ****************************************************************
module ptc_prescaler (
    input  wire logic       ref_clk,      // System clock
    input  wire logic       rst_n,        // Asynchronous reset
    input  wire logic       src_tick,     // Timer clock source pulse
    input  wire logic       restart,      // Realign divider
    input  wire logic [2:0] div_sel,      // Division minus one
    output logic            count_tick    // Counter increment pulse
);

    logic [2:0] div_count;                // Source pulses seen

    // ************************************************************
    // Divide counter
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_count <= 3'h0;
        end else if (restart) begin
            div_count <= 3'h0;
        end else if (src_tick) begin
            // Wrap after div_sel + 1 pulses
            if (div_count >= div_sel) begin
                div_count <= 3'h0;
            end else begin
                div_count <= div_count + 3'h1;
            end
        end
    end

    // Tick on the last pulse of each group
    assign count_tick = src_tick && !restart && (div_count >= div_sel);

endmodule : ptc_prescaler

// >>> tb/ptc_clock_config_assertions.sv
`timescale 1ns/1ns
// ****
// Checker for the clock configuration register
// ****
module ptc_checker (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rdata,
    input wire logic       capture_mode,
    input wire logic       pwm_counter_run,
    input wire logic       pwm_counter_ovf,
    input wire logic       pll_on,
    input wire logic [1:0] pll_divide_sel,
    input wire logic       timer_src_sel,
    input wire logic       fast_core_clk_sel,
    input wire logic [2:0] timer_prescale_sel
);
    logic       w;       // Mapped write
    logic       rd;      // Mapped read
    logic       run;     // Timer in run mode
    logic [1:0] sw_div;  // Last written divider
    logic [2:0] sw_pres; // Last written prescaler
    assign w = wr_en && addr == ptc_pkg::CLOCK_PRESCALE_CONFIG_OFFSET;
    assign rd = rd_en && addr == ptc_pkg::CLOCK_PRESCALE_CONFIG_OFFSET;
    assign run = capture_mode || pwm_counter_run;
    // Software copy of the deferred fields
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_div <= 2'h0;
            sw_pres <= 3'h0;
        end else if (w) begin
            sw_div <= wdata[6:5];
            sw_pres <= wdata[2:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Two run cycles, no overflow in the second
    sequence s_run_quiet;
        run ##1 run && !pwm_counter_ovf;
    endsequence
    a_pll_frozen: assert property (run && w |=> $stable(pll_on))
        else $error("pll enable changed in run mode");
    a_src_frozen: assert property (run && w |=> $stable(timer_src_sel))
        else $error("timer source changed in run mode");
    a_src_needs_pll: assert property (
        w && !run && !wdata[7] && wdata[4] |=> $stable(timer_src_sel))
        else $error("timer source set without pll");
    a_fast_forced: assert property (w && !run && !wdata[7] |=> !fast_core_clk_sel)
        else $error("core select not forced low");
    a_fast_free: assert property (
        w && pll_on && run |=> fast_core_clk_sel == $past(wdata[3]))
        else $error("core select not switched");
    a_active_hold: assert property (
        s_run_quiet |=> $stable(pll_divide_sel) && $stable(timer_prescale_sel))
        else $error("active fields moved before overflow");
    a_ovf_load: assert property (
        run && pwm_counter_ovf |=> pll_divide_sel == $past(sw_div)
            && timer_prescale_sel == $past(sw_pres))
        else $error("active fields not loaded at overflow");
    a_read_back: assert property (
        rd |=> rdata == {$past(pll_on), $past(sw_div), $past(timer_src_sel),
                         $past(fast_core_clk_sel), $past(sw_pres)})
        else $error("read data wrong");
    a_read_idle: assert property (!rd |=> rdata == ptc_pkg::UNMAPPED_READ_VALUE)
        else $error("read data not idle");
endmodule : ptc_checker
bind ptc_clock_config ptc_checker chk_u (.*);

// >>> tb/tb_top.sv
`timescale 1ns/1ns
// ****
// Self-checking bench for the clock configuration block
// ****
module tb_top;
    localparam logic [7:0] OFF = ptc_pkg::CLOCK_PRESCALE_CONFIG_OFFSET;
    logic ref_clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, rd_pend = 0;
    logic [7:0] addr = 0, wdata = 0, rdata, cfg = 0;
    logic capture_mode = 0, pwm_counter_run = 0, pwm_counter_ovf = 0;
    logic pll_out_tick = 1, osc_tick = 1, pll_on, timer_src_sel, fast_core_clk_sel;
    logic [1:0] pll_divide_sel;
    logic [2:0] timer_prescale_sel;
    logic timer_clk, core_instr_clk, pwm_counter_tick;
    logic [7:0] expq[$]; // Expected read data
    int errors = 0, total_checks = 0, n_tick = 0, n_core = 0, n_src = 0, t0, c0, s0, r;
    ptc_clock_config dut_u (.*);
    always #50 ref_clk = ~ref_clk;
    // Pulse counters
    always @(posedge ref_clk) begin
        n_tick += (pwm_counter_tick === 1'b1);
        n_core += (core_instr_clk === 1'b1);
        n_src += (timer_clk === 1'b1);
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic check_rate(input int got, input int exp, input string what);
        total_checks++;
        if (got < exp - 1 || got > exp + 1) begin
            errors++;
            $display("BAD %0t %s count %0d exp %0d", $time, what, got, exp);
        end
    endtask : check_rate
    // Bus write, with expected register update
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic run, p;
        @(posedge ref_clk);
        run = capture_mode | pwm_counter_run;
        addr <= a;
        wdata <= d;
        wr_en <= 1;
        @(posedge ref_clk);
        wr_en <= 0;
        if (a == OFF) begin
            p = run ? cfg[7] : d[7];
            cfg = {p, d[6:5], (run || (d[4] && !p)) ? cfg[4] : d[4], p & d[3], d[2:0]};
        end
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1;
        expq.push_back(a == OFF ? cfg : ptc_pkg::UNMAPPED_READ_VALUE);
        @(posedge ref_clk);
        rd_en <= 0;
    endtask : rd
    // Read data watcher
    always @(posedge ref_clk) begin
        if (rd_pend) check(rdata, expq.pop_front(), "read");
        rd_pend <= rd_en;
    end
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    // Watchdog
    initial begin
        #(100 * 20000);
        errors++;
        $display("BAD %0t watchdog expired", $time);
        give_verdict;
    end
    initial begin
        void'($urandom(32'h0000_b6b9));
        repeat (6) @(posedge ref_clk);
        rst_n <= 1;
        rd(OFF);
        rd(8'ha5);
        $display("reset test done");
        wr(OFF, 8'h1f);
        rd(OFF);
        repeat (60) begin
            capture_mode <= ($urandom % 4 == 0);
            pwm_counter_run <= ($urandom % 4 == 0);
            wr(($urandom % 8 == 0) ? 8'ha5 : OFF, 8'($urandom));
            rd(OFF);
        end
        capture_mode <= 0;
        pwm_counter_run <= 0;
        $display("random access test done");
        wr(OFF, 8'h80);
        wr(OFF, 8'ha1);
        repeat (3) @(posedge ref_clk);
        check({3'h0, pll_divide_sel, timer_prescale_sel}, 8'h09, "idle load");
        pwm_counter_run <= 1;
        wr(OFF, 8'hc6);
        repeat (4) @(posedge ref_clk);
        check({3'h0, pll_divide_sel, timer_prescale_sel}, 8'h09, "deferred");
        rd(OFF);
        pwm_counter_ovf <= 1;
        @(posedge ref_clk);
        pwm_counter_ovf <= 0;
        repeat (2) @(posedge ref_clk);
        check({3'h0, pll_divide_sel, timer_prescale_sel}, 8'h16, "overflow");
        pwm_counter_run <= 0;
        $display("deferral test done");
        repeat (10) begin
            wr(OFF, 8'h80 | 8'($urandom));
            repeat (20) @(negedge ref_clk);
            t0 = n_tick;
            c0 = n_core;
            s0 = n_src;
            repeat (480) @(negedge ref_clk);
            r = cfg[4] ? (8 >> cfg[6:5]) : (cfg[3] ? 8 : 2);
            check_rate(n_tick - t0, 480 / (r * (cfg[2:0] + 1)), "timer");
            check_rate(n_core - c0, 480 / (cfg[3] ? 8 : 2), "core");
            check_rate(n_src - s0, 480 / r, "source");
        end
        $display("rate test done");
        give_verdict;
    end
endmodule : tb_top
